/* src/orr_exec.sv */
// execution unit: accumulator, file registers, flags, pc and return handling
`timescale 1ns/10ps
`include "orr_exec_regs.svh"
module orr_exec #(
   parameter int STACK_DEPTH = `ORR_STACK_DEPTH
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic clkEn,
   input wire orr_pkg::orr_instr_type instr,
   input wire logic stackPush,
   input wire logic [`ORR_PC_W-1:0] pushAddr,
   input wire logic gieClear,
   output logic [`ORR_DATA_W-1:0] accum,
   output logic zeroFlag,
   output logic carryFlag,
   output logic globalIntEnable,
   output logic [`ORR_PC_W-1:0] progCounter,
   output orr_pkg::orr_fwrite_type fileWr,
   output logic [$clog2(STACK_DEPTH+1)-1:0] stackDepth
);
   import orr_pkg::*;

   logic [`ORR_DATA_W-1:0] fileMem [`ORR_FILE_WORDS];
   logic [`ORR_DATA_W-1:0] fileRd;
   logic [`ORR_DATA_W-1:0] result;
   logic [`ORR_PC_W-1:0] stackTop;
   logic issue;
   logic doRet;
   logic toFile;
   logic toAcc;
   logic setsZero;
   logic [`ORR_DATA_W-1:0] next_accum;

   function automatic logic is_zero(input logic [`ORR_DATA_W-1:0] v);
      return v == `ORR_ZERO_BYTE;
   endfunction

   assign issue = clkEn && instr.valid;
   assign doRet = issue && instr.op == OP_RET_INT;
   assign fileRd = fileMem[instr.addr];

   // operation result and where it goes
   always_comb
   begin
      result = fileRd;
      toFile = 1'b0;
      toAcc = 1'b0;
      setsZero = 1'b0;
      unique case (instr.op)
         OP_OR_LIT:
         begin
            result = accum | instr.literal;
            toAcc = 1'b1;
            setsZero = 1'b1;
         end
         OP_LOAD_LIT:
         begin
            result = instr.literal;
            toAcc = 1'b1;
         end
         OP_OR_FILE:
         begin
            result = accum | fileRd;
            toFile = instr.dest == `ORR_DEST_FILE;
            toAcc = instr.dest == `ORR_DEST_ACC;
            setsZero = 1'b1;
         end
         OP_STORE_ACC:
         begin
            result = accum;
            toFile = 1'b1;
         end
         OP_COPY_FILE:
         begin
            result = fileRd;
            toFile = instr.dest == `ORR_DEST_FILE;
            toAcc = instr.dest == `ORR_DEST_ACC;
            setsZero = 1'b1;
         end
         OP_ROT_LEFT:
         begin
            result = {fileRd[`ORR_MSB-1:0], carryFlag};
            toFile = instr.dest == `ORR_DEST_FILE;
            toAcc = instr.dest == `ORR_DEST_ACC;
         end
         OP_NOP, OP_RET_INT:
         begin
            result = fileRd;
         end
      endcase
   end

   assign next_accum = (issue && toAcc) ? result : accum;

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
         accum <= `ORR_ACC_RST;
      else
         accum <= next_accum;
   end

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
         zeroFlag <= `ORR_FLAG_RST;
      else if (issue && setsZero)
         zeroFlag <= is_zero(result);
   end

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
         carryFlag <= `ORR_FLAG_RST;
      else if (issue && instr.op == OP_ROT_LEFT)
         carryFlag <= fileRd[`ORR_MSB];
   end

   // return sets the enable; a same-cycle clear from the interrupt side loses
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
         globalIntEnable <= `ORR_FLAG_RST;
      else if (doRet)
         globalIntEnable <= `ORR_GIE_ON;
      else if (clkEn && gieClear)
         globalIntEnable <= `ORR_FLAG_RST;
   end

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
         progCounter <= `ORR_PC_RST;
      else if (doRet)
         progCounter <= stackTop;
      else if (issue)
         progCounter <= progCounter + `ORR_PC_STEP;
   end

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         for (int i = 0; i < `ORR_FILE_WORDS; i++)
            fileMem[i] <= `ORR_FILE_RST;
      end
      else if (issue && toFile)
         fileMem[instr.addr] <= result;
   end

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
         fileWr <= '0;
      else if (clkEn)
      begin
         fileWr.valid <= issue && toFile;
         fileWr.addr <= instr.addr;
         fileWr.data <= result;
      end
   end

   orr_call_stack #(
      .DEPTH(STACK_DEPTH),
      .WIDTH(`ORR_PC_W)
   ) u_stack (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .clkEn(clkEn),
      .push(stackPush),
      .pushAddr(pushAddr),
      .pop(doRet),
      .top(stackTop),
      .depth(stackDepth)
   );

   sequence s_op(orr_op_type o);
      clkEn && instr.valid && instr.op == o;
   endsequence

   a_or_literal: assert property (@(posedge sys_clk) disable iff (!resetn)
      s_op(OP_OR_LIT) |=> accum == $past(accum | instr.literal)
         && zeroFlag == ($past(accum | instr.literal) == `ORR_ZERO_BYTE))
      else $error("or-literal result or zero flag wrong");

   a_load_flags: assert property (@(posedge sys_clk) disable iff (!resetn)
      s_op(OP_LOAD_LIT) |=> accum == $past(instr.literal)
         && $stable(zeroFlag) && $stable(carryFlag))
      else $error("load-literal value or flags wrong");

   a_or_file_dest: assert property (@(posedge sys_clk) disable iff (!resetn)
      s_op(OP_OR_FILE) ##0 instr.dest |=> $stable(accum) && fileWr.valid
         && fileWr.data == $past(accum | fileRd))
      else $error("or-with-file write-back wrong");

   a_store_acc: assert property (@(posedge sys_clk) disable iff (!resetn)
      s_op(OP_STORE_ACC) |=> fileWr.valid && fileWr.data == $past(accum)
         && fileWr.addr == $past(instr.addr) && $stable(zeroFlag))
      else $error("store-accumulator wrong");

   a_copy_acc: assert property (@(posedge sys_clk) disable iff (!resetn)
      s_op(OP_COPY_FILE) ##0 !instr.dest |=> accum == $past(fileRd) && !fileWr.valid)
      else $error("copy-file to accumulator wrong");

   a_copy_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
      s_op(OP_COPY_FILE) ##0 instr.dest |=> fileWr.data == $past(fileRd)
         && zeroFlag == ($past(fileRd) == `ORR_ZERO_BYTE))
      else $error("copy-file zero flag wrong");

   a_return_pc: assert property (@(posedge sys_clk) disable iff (!resetn)
      s_op(OP_RET_INT) |=> progCounter == $past(stackTop) && globalIntEnable
         && $stable(zeroFlag) && $stable(carryFlag))
      else $error("return-from-interrupt wrong");

   a_rotate_carry: assert property (@(posedge sys_clk) disable iff (!resetn)
      s_op(OP_ROT_LEFT) ##0 !instr.dest |=> carryFlag == $past(fileRd[`ORR_MSB])
         && accum == {$past(fileRd[`ORR_MSB-1:0]), $past(carryFlag)})
      else $error("rotate-left through carry wrong");

   a_pop_depth: assert property (@(posedge sys_clk) disable iff (!resetn)
      s_op(OP_RET_INT) ##0 !stackPush ##0 stackDepth != '0
         |=> stackDepth == $past(stackDepth) - 1'b1)
      else $error("return did not pop the stack");

   a_nop_quiet: assert property (@(posedge sys_clk) disable iff (!resetn)
      s_op(OP_NOP) ##0 !gieClear |=> $stable(accum) && $stable(zeroFlag) && $stable(carryFlag)
         && $stable(globalIntEnable) && !fileWr.valid
         && progCounter == $past(progCounter) + `ORR_PC_STEP)
      else $error("no-operation changed state");
endmodule

/* src/orr_exec_regs.svh */
// constants of the or/move/rotate/return execution block
// What this block does
// - or-literal ORs accumulator with immediate, result to accumulator, zero flag updated.
// - load-literal puts immediate into accumulator, no status flag changes.
// - or-with-file ORs accumulator with file register; destination bit picks target; zero updated.
// - store-accumulator copies accumulator to addressed file register, flags untouched.
// - copy-file moves file register to accumulator, or rewrites it unchanged.
// - copy-file updates zero flag from moved value, also on write-back.
// - return-from-interrupt loads pc from top of stack, sets interrupt enable.
// - rotate-left through carry; old carry into bit 0, bit 7 out to carry.
// - returning without a same-cycle push pops the call stack; previous entry becomes the top.
`ifndef ORR_EXEC_REGS_SVH
`define ORR_EXEC_REGS_SVH
`define ORR_DATA_W 8
`define ORR_ADDR_W 7
`define ORR_PC_W 13
`define ORR_STACK_DEPTH 8
`define ORR_FILE_WORDS 128
`define ORR_MSB 7
`define ORR_DEST_ACC 1'b0
`define ORR_DEST_FILE 1'b1
`define ORR_ACC_RST 8'h00
`define ORR_FILE_RST 8'h00
`define ORR_PC_RST 13'h0000
`define ORR_PC_STEP 13'h0001
`define ORR_ZERO_BYTE 8'h00
`define ORR_FLAG_RST 1'b0
`define ORR_GIE_ON 1'b1
`endif

/* src/orr_pkg.sv */
// types shared by the execution block and its testbench
`include "orr_exec_regs.svh"
package orr_pkg;
   typedef enum logic [6:0] {
      OP_NOP = 7'h01,
      OP_OR_LIT = 7'h02,
      OP_LOAD_LIT = 7'h04,
      OP_OR_FILE = 7'h08,
      OP_STORE_ACC = 7'h10,
      OP_COPY_FILE = 7'h20,
      OP_RET_INT = 7'h40,
      OP_ROT_LEFT = 7'h00
   } orr_op_type;

   typedef struct packed {
      logic valid;
      orr_op_type op;
      logic [`ORR_DATA_W-1:0] literal;
      logic [`ORR_ADDR_W-1:0] addr;
      logic dest;
   } orr_instr_type;

   typedef struct packed {
      logic valid;
      logic [`ORR_ADDR_W-1:0] addr;
      logic [`ORR_DATA_W-1:0] data;
   } orr_fwrite_type;
endpackage

/* src/orr_call_stack.sv */
// hardware call stack: circular entries with a saturating depth count
`timescale 1ns/10ps
`include "orr_exec_regs.svh"
module orr_call_stack #(
   parameter int DEPTH = `ORR_STACK_DEPTH,
   parameter int WIDTH = `ORR_PC_W
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic clkEn,
   input wire logic push,
   input wire logic [WIDTH-1:0] pushAddr,
   input wire logic pop,
   output logic [WIDTH-1:0] top,
   output logic [$clog2(DEPTH+1)-1:0] depth
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] entry [DEPTH];
   logic [PW-1:0] topPtr;

   generate
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      begin : g_chk
         $error("stack depth must be a power of two of at least 2");
      end
   endgenerate

   assign top = entry[topPtr];

   // pointer: pop then push in one cycle overwrites the top
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
         topPtr <= '0;
      else if (clkEn && pop && !push)
         topPtr <= topPtr - PW'(1);
      else if (clkEn && push && !pop)
         topPtr <= topPtr + PW'(1);
   end

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         for (int i = 0; i < DEPTH; i++)
            entry[i] <= '0;
      end
      else if (clkEn && push)
         entry[pop ? topPtr : topPtr + PW'(1)] <= pushAddr;
   end

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
         depth <= '0;
      else if (clkEn && pop && !push && depth != '0)
         depth <= depth - 1'b1;
      else if (clkEn && push && !pop && depth != ($clog2(DEPTH+1))'(DEPTH))
         depth <= depth + 1'b1;
   end
endmodule

/* verification/testbench.sv */
// self-checking testbench for the or/move/rotate/return execution unit
`timescale 1ns/10ps
`include "orr_exec_regs.svh"
module testbench;
   import orr_pkg::*;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic clkEn = 1'b1;
   orr_instr_type instr = '0;
   logic stackPush = 1'b0;
   logic [`ORR_PC_W-1:0] pushAddr = '0;
   logic gieClear = 1'b0;
   logic [`ORR_DATA_W-1:0] accum;
   logic zeroFlag;
   logic carryFlag;
   logic globalIntEnable;
   logic [`ORR_PC_W-1:0] progCounter;
   orr_fwrite_type fileWr;
   logic [3:0] stackDepth;
   logic [`ORR_PC_W-1:0] expPc = '0;
   int nMismatch = 0;
   int checksDone = 0;

   orr_exec #(.STACK_DEPTH(8)) dut_u (
      .sys_clk(sys_clk), .resetn(resetn), .clkEn(clkEn), .instr(instr),
      .stackPush(stackPush), .pushAddr(pushAddr), .gieClear(gieClear),
      .accum(accum), .zeroFlag(zeroFlag), .carryFlag(carryFlag),
      .globalIntEnable(globalIntEnable), .progCounter(progCounter),
      .fileWr(fileWr), .stackDepth(stackDepth)
   );

   always #25 sys_clk = ~sys_clk;

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checksDone++;
      if (seen !== exp)
      begin
         nMismatch++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("mismatches %0d checks %0d", nMismatch, checksDone);
      if (nMismatch == 0 && checksDone > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // one instruction, then an idle cycle so it is not repeated
   task automatic exec(input orr_op_type op, input logic [7:0] lit, input logic [6:0] a,
                       input logic d);
      @(posedge sys_clk);
      instr <= '{valid: 1'b1, op: op, literal: lit, addr: a, dest: d};
      @(posedge sys_clk);
      instr.valid <= 1'b0;
      #1;
      if (op != OP_RET_INT)
         expPc = expPc + 13'h0001;
      chk(16'(progCounter), 16'(expPc));
   endtask

   task automatic t_reset;
      chk({accum, 5'h00, zeroFlag, carryFlag, globalIntEnable}, 16'h0000);
      chk(16'(progCounter), 16'h0000);
      chk(fileWr, 16'h0000);
      chk(16'(stackDepth), 16'h0000);
   endtask

   task automatic t_literal;
      exec(OP_LOAD_LIT, 8'h00, 7'h00, 1'b0);
      chk({accum, 7'h00, zeroFlag}, 16'h0000);
      exec(OP_OR_LIT, 8'h00, 7'h00, 1'b0);
      chk({accum, 7'h00, zeroFlag}, 16'h0001);
      exec(OP_LOAD_LIT, 8'h5a, 7'h00, 1'b0);
      chk({accum, 7'h00, zeroFlag}, 16'h5a01);
      exec(OP_OR_LIT, 8'h81, 7'h00, 1'b0);
      chk({accum, 7'h00, zeroFlag}, 16'hdb00);
      exec(OP_OR_LIT, 8'hff, 7'h00, 1'b0);
      chk({accum, 7'h00, zeroFlag}, 16'hff00);
   endtask

   task automatic t_file;
      exec(OP_STORE_ACC, 8'h00, 7'h7f, 1'b1);
      chk(fileWr, {1'b1, 7'h7f, 8'hff});
      @(posedge sys_clk);
      #1;
      chk(16'(fileWr.valid), 16'h0000);
      exec(OP_LOAD_LIT, 8'h24, 7'h00, 1'b0);
      exec(OP_OR_FILE, 8'h00, 7'h7f, 1'b0);
      chk({accum, 7'h00, zeroFlag}, 16'hff00);
      exec(OP_LOAD_LIT, 8'h00, 7'h00, 1'b0);
      exec(OP_OR_FILE, 8'h00, 7'h10, 1'b1);
      chk(fileWr, {1'b1, 7'h10, 8'h00});
      chk({accum, 7'h00, zeroFlag}, 16'h0001);
      exec(OP_LOAD_LIT, 8'h24, 7'h00, 1'b0);
      exec(OP_COPY_FILE, 8'h00, 7'h7f, 1'b0);
      chk({accum, 7'h00, zeroFlag}, 16'hff00);
      exec(OP_COPY_FILE, 8'h00, 7'h10, 1'b1);
      chk(fileWr, {1'b1, 7'h10, 8'h00});
      chk({accum, 7'h00, zeroFlag}, 16'hff01);
   endtask

   task automatic t_rotate;
      exec(OP_LOAD_LIT, 8'h80, 7'h00, 1'b0);
      exec(OP_STORE_ACC, 8'h00, 7'h03, 1'b0);
      exec(OP_ROT_LEFT, 8'h00, 7'h03, 1'b0);
      chk({accum, 7'h00, carryFlag}, 16'h0001);
      exec(OP_ROT_LEFT, 8'h00, 7'h03, 1'b1);
      chk(fileWr, {1'b1, 7'h03, 8'h01});
      chk(16'(carryFlag), 16'h0001);
      exec(OP_ROT_LEFT, 8'h00, 7'h03, 1'b0);
      chk({accum, 6'h00, zeroFlag, carryFlag}, 16'h0302);
   endtask

   task automatic t_return;
      @(posedge sys_clk);
      stackPush <= 1'b1;
      pushAddr <= 13'h0123;
      @(posedge sys_clk);
      pushAddr <= 13'h00ab;
      @(posedge sys_clk);
      stackPush <= 1'b0;
      #1;
      chk(16'(stackDepth), 16'h0002);
      expPc = 13'h00ab;
      exec(OP_RET_INT, 8'h00, 7'h00, 1'b0);
      chk({7'h00, zeroFlag, carryFlag, globalIntEnable, 2'h0, stackDepth}, 16'h0141);
      @(posedge sys_clk);
      gieClear <= 1'b1;
      @(posedge sys_clk);
      gieClear <= 1'b0;
      #1;
      chk(16'(globalIntEnable), 16'h0000);
      expPc = 13'h0123;
      exec(OP_RET_INT, 8'h00, 7'h00, 1'b0);
      chk({7'h00, zeroFlag, carryFlag, globalIntEnable, 2'h0, stackDepth}, 16'h0140);
      // push and return in one cycle: pc takes the old top, the push replaces it
      @(posedge sys_clk);
      stackPush <= 1'b1;
      pushAddr <= 13'h0055;
      @(posedge sys_clk);
      pushAddr <= 13'h0077;
      instr <= '{valid: 1'b1, op: OP_RET_INT, literal: 8'h00, addr: 7'h00, dest: 1'b0};
      @(posedge sys_clk);
      stackPush <= 1'b0;
      instr.valid <= 1'b0;
      #1;
      chk(16'(progCounter), 16'h0055);
      chk(16'(stackDepth), 16'h0001);
      expPc = 13'h0077;
      exec(OP_RET_INT, 8'h00, 7'h00, 1'b0);
      chk(16'(stackDepth), 16'h0000);
   endtask

   task automatic t_nop;
      exec(OP_NOP, 8'hff, 7'h03, 1'b1);
      chk({accum, 5'h00, zeroFlag, carryFlag, globalIntEnable}, 16'h0305);
      chk({fileWr.valid, 11'h000, stackDepth}, 16'h0000);
      @(posedge sys_clk);
      clkEn <= 1'b0;
      instr <= '{valid: 1'b1, op: OP_LOAD_LIT, literal: 8'hee, addr: 7'h00, dest: 1'b0};
      @(posedge sys_clk);
      @(posedge sys_clk);
      instr.valid <= 1'b0;
      @(posedge sys_clk);
      clkEn <= 1'b1;
      #1;
      chk({accum, 8'h00}, 16'h0300);
      chk(16'(progCounter), 16'(expPc));
   endtask

   initial
   begin
      #100000;
      nMismatch++;
      tally_and_finish();
   end

   initial
   begin
      @(posedge sys_clk);
      #1;
      t_reset();
      @(posedge sys_clk);
      resetn <= 1'b1;
      t_literal();
      t_file();
      t_rotate();
      t_return();
      t_nop();
      tally_and_finish();
   end
endmodule
